// ---- hdl/ptstc_defines.svh ----
`ifndef PTSTC_DEFINES_SVH
`define PTSTC_DEFINES_SVH
// register byte offsets
`define PTSTC_A_CFG      8'h00
`define PTSTC_A_SSINC    8'h04
`define PTSTC_A_ADDEND   8'h08
`define PTSTC_A_SEC      8'h0c
`define PTSTC_A_SUBSEC   8'h10
`define PTSTC_A_STATUS   8'h14
// config field positions
`define PTSTC_B_ENABLE   0
`define PTSTC_B_V2       1
`define PTSTC_B_DECIMAL  2
`define PTSTC_B_FILTER   3
`define PTSTC_B_FINE     4
`define PTSTC_B_UDP4     5
`define PTSTC_B_UDP6     6
`define PTSTC_B_RAWL2    7
`define PTSTC_B_EVERYRX  8
`define PTSTC_B_SEL_LO   12
`define PTSTC_B_SEL_HI   15
`define PTSTC_CFG_MASK   32'h0000f1ff
// wrap points and resets
`define PTSTC_DEC_MAX    31'h3b9ac9ff
`define PTSTC_BIN_MAX    31'h7fffffff
`define PTSTC_SSINC_RST  32'h00000028
`define PTSTC_ADDEND_RST 32'h80000000
// ptp message type codes
`define PTSTC_M_SYNC     4'h0
`define PTSTC_M_DREQ     4'h1
`define PTSTC_M_PDREQ    4'h2
`define PTSTC_M_PDRESP   4'h3
`define PTSTC_M_FOLLOW   4'h8
`define PTSTC_M_DRESP    4'h9
// axi responses
`define PTSTC_OKAY       2'b00
`define PTSTC_SLVERR     2'b10
`endif

// ---- hdl/ptstc_pkg.sv ----
package ptstc_pkg;
   typedef enum logic [3:0] {
      PTSTC_SEL_BASIC_FOUR = 4'b0000,
      PTSTC_SEL_SYNC       = 4'b0001,
      PTSTC_SEL_DELAY_REQ  = 4'b0010,
      PTSTC_SEL_EVERY      = 4'b0011,
      PTSTC_SEL_SYNC_PEER  = 4'b0100,
      PTSTC_SEL_REQ_PEER   = 4'b0101,
      PTSTC_SEL_SYNC_REQ   = 4'b0110,
      PTSTC_SEL_PEER_ONLY  = 4'b0111,
      PTSTC_SEL_NONE       = 4'b1111
   } ptstc_msg_sel_t;
   typedef enum logic [1:0] {
      PTSTC_ENC_RAW_L2 = 2'b00,
      PTSTC_ENC_UDP4   = 2'b01,
      PTSTC_ENC_UDP6   = 2'b10,
      PTSTC_ENC_OTHER  = 2'b11
   } ptstc_encap_t;
   // frame description given by a mac path at start of frame
   typedef struct packed {
      logic         is_ptp;
      ptstc_encap_t encap;
      logic [3:0]   msg_type;
      logic [3:0]   ptp_version;
      logic         dest_match;
   } ptstc_frame_t;
   // captured time
   typedef struct packed {
      logic [31:0] sec;
      logic [30:0] subsec;
   } ptstc_time_t;
endpackage

// ---- hdl/ptstc_top.sv ----
`timescale 1ns/1ps
`include "ptstc_defines.svh"
// What this block does
// - parse version 2 frames when version 2 selected, else version 1
// - decimal mode: subsecond counts nanoseconds, wraps after 999999999
// - binary mode: each subsecond lsb is about 0.465 ns
// - binary mode: 31-bit subsecond wraps after all ones, keeping the overshoot
// - seconds advance by one whenever subsecond wraps
// - filter on: only ptp frames matching station address accepted
// - filter off: destination address ignored for ptp frames
// - coarse mode: subsecond adds increment every clock
// - fine mode: 32-bit accumulator adds addend, carry advances subsecond
// - addend writable while the clock runs
// - message select chooses which ptp messages get stamped
// - udp over ipv4 frames processed only when enabled
// - udp over ipv6 frames processed only when enabled
// - raw ethernet ptp frames processed only when enabled
// - every-rx option stamps every received frame when a message subset is selected
// - every-rx with no subset selected stamps basic four messages
// - all configuration including increment reads back
// - time base stamps rx and tx and serves as system time
// - disable stops time base, enable restarts it
// - seconds wrap flags status, cleared by software read
module ptstc_top
   import ptstc_pkg::*;
(
   input  wire logic         CLK,
   input  wire logic         SRST,
   input  wire logic [7:0]   S_AXI_AWADDR,
   input  wire logic         S_AXI_AWVALID,
   output logic              S_AXI_AWREADY,
   input  wire logic [31:0]  S_AXI_WDATA,
   input  wire logic [3:0]   S_AXI_WSTRB,
   input  wire logic         S_AXI_WVALID,
   output logic              S_AXI_WREADY,
   output logic [1:0]        S_AXI_BRESP,
   output logic              S_AXI_BVALID,
   input  wire logic         S_AXI_BREADY,
   input  wire logic [7:0]   S_AXI_ARADDR,
   input  wire logic         S_AXI_ARVALID,
   output logic              S_AXI_ARREADY,
   output logic [31:0]       S_AXI_RDATA,
   output logic [1:0]        S_AXI_RRESP,
   output logic              S_AXI_RVALID,
   input  wire logic         S_AXI_RREADY,
   input  wire logic         RX_SOF,
   input  wire ptstc_frame_t RX_FRAME,
   input  wire logic         TX_SOF,
   input  wire ptstc_frame_t TX_FRAME,
   output logic              RX_STAMP_VALID,
   output ptstc_time_t       RX_STAMP,
   output logic              TX_STAMP_VALID,
   output ptstc_time_t       TX_STAMP,
   output ptstc_time_t       SYS_TIME,
   output logic              SECONDS_WRAP_FLAG
);

   // ============================================================
   // configuration state
   logic [31:0] cfg_r;
   logic [31:0] subsec_increment_r;
   logic [31:0] addend_r;
   logic [31:0] sec_r;
   logic [30:0] subsec_r;
   logic [31:0] acc_r;
   logic        seconds_wrap_flag_r;

   logic        ts_enable, ptp_v2_select, decimal_wrap_mode, dest_filter_on;
   logic        fine_update_mode, accept_udp4, accept_udp6, accept_raw_l2;
   logic        stamp_every_rx;
   ptstc_msg_sel_t msg_sel;

   assign ts_enable         = cfg_r[`PTSTC_B_ENABLE];
   assign ptp_v2_select     = cfg_r[`PTSTC_B_V2];
   assign decimal_wrap_mode = cfg_r[`PTSTC_B_DECIMAL];
   assign dest_filter_on    = cfg_r[`PTSTC_B_FILTER];
   assign fine_update_mode  = cfg_r[`PTSTC_B_FINE];
   assign accept_udp4       = cfg_r[`PTSTC_B_UDP4];
   assign accept_udp6       = cfg_r[`PTSTC_B_UDP6];
   assign accept_raw_l2     = cfg_r[`PTSTC_B_RAWL2];
   assign stamp_every_rx    = cfg_r[`PTSTC_B_EVERYRX];
   assign msg_sel           = ptstc_msg_sel_t'(cfg_r[`PTSTC_B_SEL_HI:`PTSTC_B_SEL_LO]);

   // ============================================================
   // axi4-lite write channel
   logic        aw_held_r, w_held_r;
   logic [7:0]  awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        wr_go;
   logic        wr_hit;

   assign S_AXI_AWREADY = !aw_held_r && !S_AXI_BVALID;
   assign S_AXI_WREADY  = !w_held_r && !S_AXI_BVALID;
   assign wr_go         = aw_held_r && w_held_r && !S_AXI_BVALID;

   // capture address and data in either order
   always_ff @(posedge CLK) begin
      if (SRST) begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         awaddr_r  <= 8'h00;
         wdata_r   <= 32'h00000000;
         wstrb_r   <= 4'h0;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held_r <= 1'b1;
            awaddr_r  <= S_AXI_AWADDR;
         end else if (wr_go) begin
            aw_held_r <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held_r <= 1'b1;
            wdata_r  <= S_AXI_WDATA;
            wstrb_r  <= S_AXI_WSTRB;
         end else if (wr_go) begin
            w_held_r <= 1'b0;
         end
      end
   end

   // merge write data by byte strobes
   function automatic logic [31:0] ptstc_merge(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction

   assign wr_hit = (awaddr_r == `PTSTC_A_CFG) || (awaddr_r == `PTSTC_A_SSINC)
                || (awaddr_r == `PTSTC_A_ADDEND);

   // write response, error for unmapped or read-only words
   always_ff @(posedge CLK) begin
      if (SRST) begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP  <= `PTSTC_OKAY;
      end else if (wr_go) begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP  <= wr_hit ? `PTSTC_OKAY : `PTSTC_SLVERR;
      end else if (S_AXI_BREADY) begin
         S_AXI_BVALID <= 1'b0;
      end
   end

   // config register; enable bit starts or stops the time base
   always_ff @(posedge CLK) begin
      if (SRST) begin
         cfg_r <= 32'h00000000;
      end else if (wr_go && awaddr_r == `PTSTC_A_CFG) begin
         cfg_r <= ptstc_merge(cfg_r, wdata_r, wstrb_r) & `PTSTC_CFG_MASK;
      end
   end

   // increment and addend, writable at any time
   always_ff @(posedge CLK) begin
      if (SRST) begin
         subsec_increment_r <= `PTSTC_SSINC_RST;
         addend_r           <= `PTSTC_ADDEND_RST;
      end else if (wr_go) begin
         if (awaddr_r == `PTSTC_A_SSINC) begin
            subsec_increment_r <= ptstc_merge(subsec_increment_r, wdata_r, wstrb_r);
         end
         if (awaddr_r == `PTSTC_A_ADDEND) begin
            addend_r <= ptstc_merge(addend_r, wdata_r, wstrb_r);
         end
      end
   end

   // ============================================================
   // time base
   logic [32:0] acc_sum;
   logic        tick;
   logic [32:0] ss_sum;
   logic [30:0] wrap_max;
   logic        wrap;
   logic [30:0] ss_next;

   assign acc_sum  = {1'b0, acc_r} + {1'b0, addend_r};
   assign tick     = ts_enable && (fine_update_mode ? acc_sum[32] : 1'b1);
   assign wrap_max = decimal_wrap_mode ? `PTSTC_DEC_MAX : `PTSTC_BIN_MAX;
   assign ss_sum   = {2'b00, subsec_r} + {1'b0, subsec_increment_r};
   assign wrap     = ss_sum > {2'b00, wrap_max};
   // wrap keeps the overshoot so long-run rate is exact
   assign ss_next  = wrap ? 31'(ss_sum - {2'b00, wrap_max} - 33'h000000001)
                          : ss_sum[30:0];

   // accumulator runs only in fine mode while enabled
   always_ff @(posedge CLK) begin
      if (SRST) begin
         acc_r <= 32'h00000000;
      end else if (ts_enable && fine_update_mode) begin
         acc_r <= acc_sum[31:0];
      end
   end

   // subsecond and seconds counters
   always_ff @(posedge CLK) begin
      if (SRST) begin
         subsec_r <= 31'h00000000;
         sec_r    <= 32'h00000000;
      end else if (tick) begin
         subsec_r <= ss_next;
         if (wrap) begin
            sec_r <= sec_r + 32'h00000001;
         end
      end
   end

   assign SYS_TIME = '{sec: sec_r, subsec: subsec_r};

   // ============================================================
   // seconds wrap status; a new wrap beats the read clear
   logic rd_go;
   logic [7:0] araddr_q;
   logic sec_wrap_ev;
   assign sec_wrap_ev = tick && wrap && (sec_r == 32'hffffffff);

   always_ff @(posedge CLK) begin
      if (SRST) begin
         seconds_wrap_flag_r <= 1'b0;
      end else if (sec_wrap_ev) begin
         seconds_wrap_flag_r <= 1'b1;
      end else if (rd_go && araddr_q == `PTSTC_A_STATUS) begin
         seconds_wrap_flag_r <= 1'b0;
      end
   end
   assign SECONDS_WRAP_FLAG = seconds_wrap_flag_r;

   // ============================================================
   // frame qualification
   function automatic logic ptstc_msg_ok(input ptstc_msg_sel_t sel,
                                         input logic [3:0] mt,
                                         input logic every_rx);
      logic basic, sy, dq, pq;
      basic = (mt == `PTSTC_M_SYNC) || (mt == `PTSTC_M_FOLLOW)
           || (mt == `PTSTC_M_DREQ) || (mt == `PTSTC_M_DRESP);
      sy = (mt == `PTSTC_M_SYNC);
      dq = (mt == `PTSTC_M_DREQ);
      pq = (mt == `PTSTC_M_PDREQ) || (mt == `PTSTC_M_PDRESP);
      unique case (sel)
         PTSTC_SEL_BASIC_FOUR: return basic;
         PTSTC_SEL_SYNC:       return sy;
         PTSTC_SEL_DELAY_REQ:  return dq;
         PTSTC_SEL_EVERY:      return 1'b1;
         PTSTC_SEL_SYNC_PEER:  return sy || pq;
         PTSTC_SEL_REQ_PEER:   return dq || pq;
         PTSTC_SEL_SYNC_REQ:   return dq;     // stamps delay request only
         PTSTC_SEL_PEER_ONLY:  return pq;
         PTSTC_SEL_NONE:       return every_rx && basic;
         default:              return 1'b0;
      endcase
   endfunction

   function automatic logic ptstc_qualify(input ptstc_frame_t f);
      logic enc_ok, ver_ok, addr_ok;
      enc_ok = (f.encap == PTSTC_ENC_UDP4   && accept_udp4)
            || (f.encap == PTSTC_ENC_UDP6   && accept_udp6)
            || (f.encap == PTSTC_ENC_RAW_L2 && accept_raw_l2);
      ver_ok  = ptp_v2_select ? (f.ptp_version == 4'h2) : (f.ptp_version == 4'h1);
      addr_ok = !dest_filter_on || f.dest_match;
      return f.is_ptp && enc_ok && ver_ok && addr_ok
          && ptstc_msg_ok(msg_sel, f.msg_type, stamp_every_rx);
   endfunction

   logic rx_take, tx_take;
   assign rx_take = RX_SOF && ts_enable && (stamp_every_rx && msg_sel != PTSTC_SEL_NONE
                    ? 1'b1 : ptstc_qualify(RX_FRAME));
   assign tx_take = TX_SOF && ts_enable && ptstc_qualify(TX_FRAME);

   // stamps come from flip-flops, one cycle after start of frame
   always_ff @(posedge CLK) begin
      if (SRST) begin
         RX_STAMP_VALID <= 1'b0;
         TX_STAMP_VALID <= 1'b0;
         RX_STAMP       <= '0;
         TX_STAMP       <= '0;
      end else begin
         RX_STAMP_VALID <= rx_take;
         TX_STAMP_VALID <= tx_take;
         if (rx_take) begin
            RX_STAMP <= SYS_TIME;
         end
         if (tx_take) begin
            TX_STAMP <= SYS_TIME;
         end
      end
   end

   // ============================================================
   // axi4-lite read channel
   assign S_AXI_ARREADY = !S_AXI_RVALID;
   assign rd_go         = S_AXI_ARVALID && S_AXI_ARREADY;
   assign araddr_q      = S_AXI_ARADDR;

   always_ff @(posedge CLK) begin
      if (SRST) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA  <= 32'h00000000;
         S_AXI_RRESP  <= `PTSTC_OKAY;
      end else if (rd_go) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RRESP  <= `PTSTC_OKAY;
         unique case (S_AXI_ARADDR)
            `PTSTC_A_CFG:    S_AXI_RDATA <= cfg_r;
            `PTSTC_A_SSINC:  S_AXI_RDATA <= subsec_increment_r;
            `PTSTC_A_ADDEND: S_AXI_RDATA <= addend_r;
            `PTSTC_A_SEC:    S_AXI_RDATA <= sec_r;
            `PTSTC_A_SUBSEC: S_AXI_RDATA <= {1'b0, subsec_r};
            `PTSTC_A_STATUS: S_AXI_RDATA <= {31'h00000000, seconds_wrap_flag_r};
            default: begin
               S_AXI_RDATA <= 32'h00000000;
               S_AXI_RRESP <= `PTSTC_SLVERR;
            end
         endcase
      end else if (S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end

   // ============================================================
   // assertions
   a_coarse_step: assert property (@(posedge CLK) disable iff (SRST)
      (ts_enable && !fine_update_mode && !wrap)
      |=> subsec_r == $past(subsec_r) + 31'($past(subsec_increment_r)))
      else $error("coarse step wrong");
   a_fine_hold: assert property (@(posedge CLK) disable iff (SRST)
      (fine_update_mode && !acc_sum[32]) |=> $stable(subsec_r) && $stable(sec_r))
      else $error("fine mode moved without carry");
   a_sec_inc: assert property (@(posedge CLK) disable iff (SRST)
      (tick && wrap) |=> sec_r == $past(sec_r) + 32'h00000001)
      else $error("seconds did not advance");
   a_dec_bound: assert property (@(posedge CLK) disable iff (SRST)
      (decimal_wrap_mode && subsec_r <= `PTSTC_DEC_MAX) |=>
      ($past(decimal_wrap_mode) != decimal_wrap_mode) || subsec_r <= `PTSTC_DEC_MAX)
      else $error("decimal subsecond exceeded limit");
   a_stop_time: assert property (@(posedge CLK) disable iff (SRST)
      !ts_enable [*2] |-> $stable(subsec_r) && $stable(acc_r))
      else $error("time base ran while disabled");
   a_flag_clear: assert property (@(posedge CLK) disable iff (SRST)
      (rd_go && araddr_q == `PTSTC_A_STATUS && !sec_wrap_ev) |=> !seconds_wrap_flag_r)
      else $error("wrap flag not cleared by read");
   a_filter: assert property (@(posedge CLK) disable iff (SRST)
      (TX_SOF && dest_filter_on && !TX_FRAME.dest_match) |=> !TX_STAMP_VALID)
      else $error("filtered frame stamped");
   a_every_rx: assert property (@(posedge CLK) disable iff (SRST)
      (RX_SOF && ts_enable && stamp_every_rx && msg_sel != PTSTC_SEL_NONE)
      |=> RX_STAMP_VALID && RX_STAMP == $past(SYS_TIME))
      else $error("rx frame not stamped");
   a_enc_udp4: assert property (@(posedge CLK) disable iff (SRST)
      (TX_SOF && TX_FRAME.encap == PTSTC_ENC_UDP4 && !accept_udp4) |=> !TX_STAMP_VALID)
      else $error("udp4 frame stamped while disabled");
   c_sec_wrap: cover property (@(posedge CLK) tick && wrap);
   c_fine_carry: cover property (@(posedge CLK) fine_update_mode && tick);
   c_tx_stamp: cover property (@(posedge CLK) TX_STAMP_VALID);
   c_flag: cover property (@(posedge CLK) seconds_wrap_flag_r);
endmodule

// ---- verif/ptp_timestamp_clock_config_test.sv ----
`timescale 1ns/1ps
`include "ptstc_defines.svh"
module ptp_timestamp_clock_config_test
   import ptstc_pkg::*;
;
   // ==================================================
   // stimulus and observed signals
   // ==================================================
   logic         clk = 1'b0;
   logic         srst = 1'b1;
   logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
   logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic         arvalid = 1'b0, rready = 1'b0;
   logic [31:0]  wdata = 32'h0;
   logic [3:0]   wstrb = 4'h0;
   logic         awready, wready, bvalid, arready, rvalid, rx_sof, tx_sof, rx_v, tx_v, wrapf;
   logic [1:0]   bresp, rresp;
   logic [31:0]  rdata;
   ptstc_frame_t rx_frame, tx_frame;
   ptstc_time_t  rx_st, tx_st, sys_t;
   int           n_errors = 0;
   int           tests_run = 0;
   localparam longint DMAX = 999999999;
   localparam longint BMAX = 64'h7fffffff;
   logic [3:0] sels [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hf};
   logic [5:0] masks [9] = '{6'h33, 6'h01, 6'h02, 6'h3f, 6'h0d, 6'h0e, 6'h02, 6'h0c, 6'h00};
   logic [3:0] mts [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9};

   // 25 MHz clock
   always #20 clk = ~clk;

   ptstc_top dut (
      .CLK(clk), .SRST(srst),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .RX_SOF(rx_sof), .RX_FRAME(rx_frame), .TX_SOF(tx_sof), .TX_FRAME(tx_frame),
      .RX_STAMP_VALID(rx_v), .RX_STAMP(rx_st), .TX_STAMP_VALID(tx_v), .TX_STAMP(tx_st),
      .SYS_TIME(sys_t), .SECONDS_WRAP_FLAG(wrapf)
   );
   ptstc_mac_model mdl (
      .clk(clk), .rx_sof(rx_sof), .rx_frame(rx_frame), .tx_sof(tx_sof), .tx_frame(tx_frame)
   );

   // ==================================================
   // shared tasks
   // ==================================================
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic give_up();
      n_errors++;
      $display("MISMATCH at %0t: wait ran out", $time);
      finish_test();
   endtask
   task automatic do_reset();
      @(posedge clk);
      srst <= 1'b1;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
   endtask
   // handshakes judged at the falling edge, where ready and valid are settled
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bit aw_hs, w_hs, b_hs;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      repeat (50) begin
         @(negedge clk);
         aw_hs = awvalid && awready;
         w_hs = wvalid && wready;
         b_hs = bvalid;
         if (b_hs) chk(bresp, er, "write response");
         @(posedge clk);
         if (aw_hs) awvalid <= 1'b0;
         if (w_hs) wvalid <= 1'b0;
         if (b_hs) begin
            bready <= 1'b0;
            return;
         end
      end
      give_up();
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      bit ar_hs, r_hs;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      repeat (50) begin
         @(negedge clk);
         ar_hs = arvalid && arready;
         r_hs = rvalid;
         if (r_hs) chk({rresp, rdata}, {er, e}, "read answer");
         @(posedge clk);
         if (ar_hs) arvalid <= 1'b0;
         if (r_hs) begin
            rready <= 1'b0;
            return;
         end
      end
      give_up();
   endtask
   task automatic now(output ptstc_time_t t);
      @(posedge clk);
      #1 t = sys_t;
   endtask
   // expected next time worked out per cycle, wrap and carry included
   task automatic step_chk(input longint inc, input longint mx, input int n);
      ptstc_time_t a, b;
      longint s;
      logic [31:0] e_sec;
      now(a);
      repeat (n) begin
         now(b);
         s = longint'(a.subsec) + inc;
         e_sec = a.sec;
         if (s > mx) begin
            s = s - mx - 1;
            e_sec = a.sec + 32'h1;
         end
         chk(b.subsec, s[30:0], "subsecond step");
         chk(b.sec, e_sec, "seconds carry");
         a = b;
      end
   endtask
   // subsecond advance over eight cycles
   task automatic span(input logic [30:0] d);
      ptstc_time_t a, b;
      now(a);
      repeat (7) @(posedge clk);
      now(b);
      chk(b.subsec - a.subsec, d, "fine advance");
   endtask
   function automatic ptstc_frame_t mk(logic p, ptstc_encap_t e, logic [3:0] mt,
                                       logic [3:0] v, logic dm);
      mk = '{p, e, mt, v, dm};
   endfunction
   task automatic fr(input bit rx, input ptstc_frame_t f, input logic exp);
      ptstc_time_t t0;
      mdl.start(rx, f);
      #1 t0 = sys_t;
      mdl.stop();
      #1 chk(rx ? rx_v : tx_v, exp, "stamp pulse");
      if (exp) chk(rx ? rx_st : tx_st, t0, "stamp value");
      chk(rx ? tx_v : rx_v, 1'b0, "other path quiet");
      @(posedge clk);
      #1 chk(rx ? rx_v : tx_v, 1'b0, "pulse length");
   endtask
   task automatic q(input logic [31:0] cfg, input ptstc_frame_t f, input logic exp);
      axi_wr(`PTSTC_A_CFG, cfg, `PTSTC_OKAY);
      fr(1'b1, f, exp);
   endtask

   // ==================================================
   // scenarios
   // ==================================================
   task automatic t_reset();
      rd_chk(`PTSTC_A_CFG, 32'h0, `PTSTC_OKAY);
      rd_chk(`PTSTC_A_SSINC, 32'h28, `PTSTC_OKAY);
      rd_chk(`PTSTC_A_ADDEND, 32'h80000000, `PTSTC_OKAY);
      rd_chk(`PTSTC_A_STATUS, 32'h0, `PTSTC_OKAY);
      rd_chk(8'h18, 32'h0, `PTSTC_SLVERR);
      axi_wr(`PTSTC_A_SEC, 32'h5, `PTSTC_SLVERR);
      rd_chk(`PTSTC_A_SEC, 32'h0, `PTSTC_OKAY);
      chk(wrapf, 1'b0, "wrap flag after reset");
      step_chk(0, DMAX, 4);
      fr(1'b1, mk(1'b1, PTSTC_ENC_UDP4, 4'h0, 4'h1, 1'b1), 1'b0);
      $display("test reset done");
   endtask
   task automatic t_coarse();
      axi_wr(`PTSTC_A_SSINC, 32'd40, `PTSTC_OKAY);
      axi_wr(`PTSTC_A_CFG, 32'h5, `PTSTC_OKAY);
      step_chk(40, DMAX, 4);
      rd_chk(`PTSTC_A_CFG, 32'h5, `PTSTC_OKAY);
      rd_chk(`PTSTC_A_SSINC, 32'd40, `PTSTC_OKAY);
      axi_wr(`PTSTC_A_SSINC, 32'd100, `PTSTC_OKAY);
      step_chk(100, DMAX, 3);
      axi_wr(`PTSTC_A_CFG, 32'h4, `PTSTC_OKAY);
      step_chk(0, DMAX, 3);
      axi_wr(`PTSTC_A_CFG, 32'h5, `PTSTC_OKAY);
      step_chk(100, DMAX, 2);
      $display("test coarse done");
   endtask
   task automatic t_wrap();
      do_reset();
      axi_wr(`PTSTC_A_SSINC, 32'd300000000, `PTSTC_OKAY);
      axi_wr(`PTSTC_A_CFG, 32'h5, `PTSTC_OKAY);
      step_chk(300000000, DMAX, 8);
      // seconds moved but never from all ones, so the flag must stay low
      chk(wrapf, 1'b0, "wrap flag on small seconds");
      do_reset();
      axi_wr(`PTSTC_A_SSINC, 32'h30000000, `PTSTC_OKAY);
      axi_wr(`PTSTC_A_CFG, 32'h1, `PTSTC_OKAY);
      step_chk(64'h30000000, BMAX, 8);
      $display("test wrap done");
   endtask
   task automatic t_fine();
      do_reset();
      axi_wr(`PTSTC_A_SSINC, 32'd80, `PTSTC_OKAY);
      axi_wr(`PTSTC_A_CFG, 32'h15, `PTSTC_OKAY);
      span(31'd320);
      axi_wr(`PTSTC_A_ADDEND, 32'h40000000, `PTSTC_OKAY);
      span(31'd160);
      rd_chk(`PTSTC_A_ADDEND, 32'h40000000, `PTSTC_OKAY);
      $display("test fine done");
   endtask
   // every select code against every message type, both paths
   task automatic t_select();
      for (int i = 0; i < 9; i++) begin
         axi_wr(`PTSTC_A_CFG, {16'h0, sels[i], 12'h0e3}, `PTSTC_OKAY);
         for (int j = 0; j < 6; j++) begin
            fr(1'b1, mk(1'b1, PTSTC_ENC_UDP4, mts[j], 4'h2, 1'b1), masks[i][j]);
            fr(1'b0, mk(1'b1, PTSTC_ENC_UDP6, mts[j], 4'h2, 1'b1), masks[i][j]);
         end
      end
      $display("test select done");
   endtask
   task automatic t_qual();
      q(32'he3, mk(1'b1, PTSTC_ENC_UDP4, 4'h0, 4'h1, 1'b1), 1'b0);
      q(32'he1, mk(1'b1, PTSTC_ENC_UDP4, 4'h0, 4'h1, 1'b1), 1'b1);
      q(32'he1, mk(1'b1, PTSTC_ENC_UDP4, 4'h0, 4'h2, 1'b1), 1'b0);
      q(32'hc3, mk(1'b1, PTSTC_ENC_UDP4, 4'h0, 4'h2, 1'b1), 1'b0);
      fr(1'b0, mk(1'b1, PTSTC_ENC_UDP4, 4'h0, 4'h2, 1'b1), 1'b0);
      q(32'hc3, mk(1'b1, PTSTC_ENC_UDP6, 4'h0, 4'h2, 1'b1), 1'b1);
      q(32'ha3, mk(1'b1, PTSTC_ENC_UDP6, 4'h0, 4'h2, 1'b1), 1'b0);
      q(32'ha3, mk(1'b1, PTSTC_ENC_RAW_L2, 4'h0, 4'h2, 1'b1), 1'b1);
      q(32'h63, mk(1'b1, PTSTC_ENC_RAW_L2, 4'h0, 4'h2, 1'b1), 1'b0);
      q(32'heb, mk(1'b1, PTSTC_ENC_UDP4, 4'h0, 4'h2, 1'b0), 1'b0);
      fr(1'b0, mk(1'b1, PTSTC_ENC_UDP4, 4'h0, 4'h2, 1'b0), 1'b0);
      q(32'heb, mk(1'b1, PTSTC_ENC_UDP4, 4'h0, 4'h2, 1'b1), 1'b1);
      q(32'he3, mk(1'b1, PTSTC_ENC_UDP4, 4'h0, 4'h2, 1'b0), 1'b1);
      q(32'h1e3, mk(1'b0, PTSTC_ENC_OTHER, 4'h5, 4'h0, 1'b0), 1'b1);
      q(32'hf1e3, mk(1'b1, PTSTC_ENC_UDP4, 4'h9, 4'h2, 1'b1), 1'b1);
      q(32'hf1e3, mk(1'b1, PTSTC_ENC_UDP4, 4'h2, 4'h2, 1'b1), 1'b0);
      // a select code outside the listed choices stamps nothing
      q(32'h80e3, mk(1'b1, PTSTC_ENC_UDP4, 4'h0, 4'h2, 1'b1), 1'b0);
      $display("test qualify done");
   endtask

   // main sequence; reset held four cycles, first request on the edge after release
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_coarse();
      t_wrap();
      t_fine();
      t_select();
      t_qual();
      finish_test();
   end
endmodule

// ---- verif/ptstc_mac_model.sv ----
`timescale 1ns/1ps
// ==================================================
// mac frame path model
// ==================================================
// stands in for the receive and transmit frame paths; every stop inverts both descriptors,
// the idle path's as well as the one just started, so a stale one flips at every stop
module ptstc_mac_model
   import ptstc_pkg::*;
(
   input  wire logic   clk,
   output logic         rx_sof,
   output ptstc_frame_t rx_frame,
   output logic         tx_sof,
   output ptstc_frame_t tx_frame
);
   // quiet paths at time zero
   initial begin
      rx_sof = 1'b0;
      tx_sof = 1'b0;
      rx_frame = '0;
      tx_frame = '0;
   end
   // one start of frame on the chosen path, driven just after an edge
   task automatic start(input bit rx, input ptstc_frame_t f);
      @(posedge clk);
      if (rx) begin
         rx_sof <= 1'b1;
         rx_frame <= f;
      end else begin
         tx_sof <= 1'b1;
         tx_frame <= f;
      end
   endtask
   // descriptor expires after one cycle
   task automatic stop();
      @(posedge clk);
      rx_sof <= 1'b0;
      tx_sof <= 1'b0;
      rx_frame <= ~rx_frame;
      tx_frame <= ~tx_frame;
   endtask
endmodule
